// *** cbmic_pkg.sv ***
// Overview of operation
// - Mode bits 7:6 and 3:2 read zero
// - Bit 5 enables rising-edge interrupt
// - Bit 4 enables falling-edge interrupt
// - Bits 1:0 select response-time mode
// - Mode register resets to 00000010
// - Edge flags set on transition, sticky
// - Disabled comparator: pin low, interrupts suspended
// - Output-state bit follows comparator result while enabled, reads 0 when disabled
package cbmic_pkg;
    localparam logic [7:0] CBMIC_MODE_ADDR = 8'h89;
    localparam logic [7:0] CBMIC_CTRL_ADDR = 8'h88;
    localparam logic [7:0] CBMIC_MODE_RESET = 8'h02;
    localparam logic [7:0] CBMIC_CTRL_RESET = 8'h00;
    localparam logic [7:0] CBMIC_MODE_MASK = 8'h33;
    localparam int CBMIC_RIE_BIT = 5;
    localparam int CBMIC_FIE_BIT = 4;
    localparam int CBMIC_EN_BIT = 7;
    localparam int CBMIC_OUT_BIT = 6;
    localparam int CBMIC_RIF_BIT = 5;
    localparam int CBMIC_FIF_BIT = 4;
    localparam logic [7:0] CBMIC_HYS_MASK = 8'h0F;
    typedef enum logic [1:0] {
        CBMIC_MODE_FAST = 2'h0,
        CBMIC_MODE_1 = 2'h1,
        CBMIC_MODE_2 = 2'h2,
        CBMIC_MODE_LOW_POWER = 2'h3
    } cbmic_mode_t;
endpackage

// *** cbmic_edge_det.sv ***
module cbmic_edge_det
    import cbmic_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic level,
    input wire logic arm,
    output logic rise,
    output logic fall
);
    logic last;
    logic armed;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            last <= 1'b0;
            armed <= 1'b0;
        end else begin
            last <= level;
            armed <= arm;
        end
    end

    // Edges only count once the previous sample was taken while enabled
    always_comb begin
        rise = armed && arm && level && !last;
        fall = armed && arm && !level && last;
    end
endmodule

// *** cbmic_top.sv ***
module cbmic_top
    import cbmic_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic cmp_result,
    output logic [7:0] sfr_rdata,
    output logic comparator_b_irq,
    output logic comparator_b_pin,
    output logic [1:0] response_mode,
    output logic [1:0] hys_pos,
    output logic [1:0] hys_neg,
    output logic comparator_b_enable
);
    logic rise_irq_enable;
    logic fall_irq_enable;
    logic response_mode_hi;
    logic response_mode_lo;
    logic rise_edge_flag;
    logic fall_edge_flag;
    logic [3:0] hysteresis;
    logic comparator_b_output_state;
    logic edge_rise;
    logic edge_fall;
    logic wr_mode;
    logic wr_ctrl;
    logic [7:0] mode_view;
    logic [7:0] ctrl_view;

    // Strobe qualified by an exact address match; shared by every access path
    function automatic logic reg_hit(input logic strobe, input logic [7:0] addr, input logic [7:0] target);
        return strobe && (addr == target);
    endfunction

    assign wr_mode = reg_hit(sfr_wr, sfr_addr, CBMIC_MODE_ADDR);
    assign wr_ctrl = reg_hit(sfr_wr, sfr_addr, CBMIC_CTRL_ADDR);

    // Disabled comparator result is forced low
    assign comparator_b_output_state = comparator_b_enable & cmp_result;

    cbmic_edge_det u_edge (
        .clk(clk),
        .rst_n(rst_n),
        .level(comparator_b_output_state),
        .arm(comparator_b_enable),
        .rise(edge_rise),
        .fall(edge_fall)
    );

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rise_irq_enable <= CBMIC_MODE_RESET[CBMIC_RIE_BIT];
            fall_irq_enable <= CBMIC_MODE_RESET[CBMIC_FIE_BIT];
            response_mode_hi <= CBMIC_MODE_RESET[1];
            response_mode_lo <= CBMIC_MODE_RESET[0];
        end else if (wr_mode) begin
            // Unused bits are simply not stored
            rise_irq_enable <= sfr_wdata[CBMIC_RIE_BIT];
            fall_irq_enable <= sfr_wdata[CBMIC_FIE_BIT];
            response_mode_hi <= sfr_wdata[1];
            response_mode_lo <= sfr_wdata[0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            comparator_b_enable <= CBMIC_CTRL_RESET[CBMIC_EN_BIT];
            hysteresis <= CBMIC_CTRL_RESET[3:0];
        end else if (wr_ctrl) begin
            comparator_b_enable <= sfr_wdata[CBMIC_EN_BIT];
            hysteresis <= sfr_wdata[3:0];
        end
    end

    // Hardware set beats a same-cycle software clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rise_edge_flag <= CBMIC_CTRL_RESET[CBMIC_RIF_BIT];
            fall_edge_flag <= CBMIC_CTRL_RESET[CBMIC_FIF_BIT];
        end else begin
            if (edge_rise) begin
                rise_edge_flag <= 1'b1;
            end else if (wr_ctrl) begin
                rise_edge_flag <= sfr_wdata[CBMIC_RIF_BIT];
            end
            if (edge_fall) begin
                fall_edge_flag <= 1'b1;
            end else if (wr_ctrl) begin
                fall_edge_flag <= sfr_wdata[CBMIC_FIF_BIT];
            end
        end
    end

    always_comb begin
        mode_view = {2'h0, rise_irq_enable, fall_irq_enable, 2'h0, response_mode_hi, response_mode_lo};
        ctrl_view = {comparator_b_enable, comparator_b_output_state, rise_edge_flag, fall_edge_flag, hysteresis};
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sfr_rdata <= 8'h00;
        end else if (reg_hit(sfr_rd, sfr_addr, CBMIC_MODE_ADDR)) begin
            sfr_rdata <= mode_view;
        end else if (reg_hit(sfr_rd, sfr_addr, CBMIC_CTRL_ADDR)) begin
            sfr_rdata <= ctrl_view;
        end else begin
            sfr_rdata <= 8'h00;
        end
    end

    // Registered outputs; one cycle of latency is harmless for an interrupt line
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            comparator_b_irq <= 1'b0;
            comparator_b_pin <= 1'b0;
            response_mode <= CBMIC_MODE_RESET[1:0];
            hys_pos <= 2'h0;
            hys_neg <= 2'h0;
        end else begin
            comparator_b_irq <= comparator_b_enable &&
                ((rise_edge_flag && rise_irq_enable) || (fall_edge_flag && fall_irq_enable));
            comparator_b_pin <= comparator_b_output_state;
            response_mode <= {response_mode_hi, response_mode_lo};
            hys_pos <= hysteresis[3:2];
            hys_neg <= hysteresis[1:0];
        end
    end

    property p_reset_mode;
        @(posedge clk) $rose(rst_n) |-> (mode_view == CBMIC_MODE_RESET);
    endproperty
    a_reset_mode: assert property (p_reset_mode) else $error("mode reset value wrong");

    property p_unused_zero;
        @(posedge clk) disable iff (!rst_n)
            sfr_rd && sfr_addr == CBMIC_MODE_ADDR |=> (sfr_rdata & ~CBMIC_MODE_MASK) == 8'h00;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused mode bits nonzero");

    property p_rie_write;
        @(posedge clk) disable iff (!rst_n) wr_mode |=> rise_irq_enable == $past(sfr_wdata[CBMIC_RIE_BIT]);
    endproperty
    a_rie_write: assert property (p_rie_write) else $error("rise enable not written");

    property p_fie_write;
        @(posedge clk) disable iff (!rst_n) wr_mode |=> fall_irq_enable == $past(sfr_wdata[CBMIC_FIE_BIT]);
    endproperty
    a_fie_write: assert property (p_fie_write) else $error("fall enable not written");

    property p_mode_out;
        @(posedge clk) disable iff (!rst_n) wr_mode |=> ##1 response_mode == $past(sfr_wdata[1:0], 2);
    endproperty
    a_mode_out: assert property (p_mode_out) else $error("response mode output wrong");

    property p_rise_sets;
        @(posedge clk) disable iff (!rst_n) edge_rise |=> rise_edge_flag;
    endproperty
    a_rise_sets: assert property (p_rise_sets) else $error("rise flag not set");

    property p_fall_sticky;
        @(posedge clk) disable iff (!rst_n) fall_edge_flag && !wr_ctrl |=> fall_edge_flag;
    endproperty
    a_fall_sticky: assert property (p_fall_sticky) else $error("fall flag lost");

    property p_disabled_quiet;
        @(posedge clk) disable iff (!rst_n) !comparator_b_enable |=> !comparator_b_irq && !comparator_b_pin;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled comparator active");

    property p_irq;
        @(posedge clk) disable iff (!rst_n)
            comparator_b_enable && rise_edge_flag && rise_irq_enable |=> comparator_b_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");

    property p_irq_fall;
        @(posedge clk) disable iff (!rst_n)
            comparator_b_enable && fall_edge_flag && fall_irq_enable |=> comparator_b_irq;
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("fall irq missing");

    property p_irq_needs_cause;
        @(posedge clk) disable iff (!rst_n)
            !(rise_edge_flag && rise_irq_enable) && !(fall_edge_flag && fall_irq_enable) |=> !comparator_b_irq;
    endproperty
    a_irq_needs_cause: assert property (p_irq_needs_cause) else $error("irq without enabled flag");

    property p_fall_sets;
        @(posedge clk) disable iff (!rst_n) edge_fall |=> fall_edge_flag;
    endproperty
    a_fall_sets: assert property (p_fall_sets) else $error("fall flag not set");

    property p_rise_sticky;
        @(posedge clk) disable iff (!rst_n) rise_edge_flag && !wr_ctrl |=> rise_edge_flag;
    endproperty
    a_rise_sticky: assert property (p_rise_sticky) else $error("rise flag lost");

    property p_pin_follows;
        @(posedge clk) disable iff (!rst_n) comparator_b_enable |=> comparator_b_pin == $past(cmp_result);
    endproperty
    a_pin_follows: assert property (p_pin_follows) else $error("pin does not follow result");

    property p_no_edge_off;
        @(posedge clk) disable iff (!rst_n) !comparator_b_enable |-> !edge_rise && !edge_fall;
    endproperty
    a_no_edge_off: assert property (p_no_edge_off) else $error("edge seen while disabled");

    property p_rie_hold;
        @(posedge clk) disable iff (!rst_n) !wr_mode |=> $stable(rise_irq_enable);
    endproperty
    a_rie_hold: assert property (p_rie_hold) else $error("rise enable changed without write");

    property p_mode_hold;
        @(posedge clk) disable iff (!rst_n)
            !wr_mode |=> $stable(response_mode_hi) && $stable(response_mode_lo);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed without write");

    property p_ctrl_reset;
        @(posedge clk) $rose(rst_n) |-> !comparator_b_enable && !rise_edge_flag && !fall_edge_flag;
    endproperty
    a_ctrl_reset: assert property (p_ctrl_reset) else $error("control reset value wrong");

    c_rise: cover property (@(posedge clk) disable iff (!rst_n) edge_rise ##1 comparator_b_irq);
    c_fall: cover property (@(posedge clk) disable iff (!rst_n) edge_fall ##1 fall_edge_flag);
    c_clear: cover property (@(posedge clk) disable iff (!rst_n) rise_edge_flag ##1 wr_ctrl ##1 !rise_edge_flag);
    c_set_wins: cover property (@(posedge clk) disable iff (!rst_n) edge_rise && wr_ctrl ##1 rise_edge_flag);
endmodule

// *** cbmic_top_tb.sv ***
module cbmic_top_tb
    import cbmic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic cmp_result = 1'b0;
    logic [7:0] sfr_rdata;
    logic comparator_b_irq;
    logic comparator_b_pin;
    logic [1:0] response_mode;
    logic [1:0] hys_pos;
    logic [1:0] hys_neg;
    logic comparator_b_enable;
    logic [31:0] seed = 32'h4F43;
    int fail_count = 0;
    int n_compared = 0;

    cbmic_top dut (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .cmp_result(cmp_result), .sfr_rdata(sfr_rdata), .comparator_b_irq(comparator_b_irq),
        .comparator_b_pin(comparator_b_pin), .response_mode(response_mode), .hys_pos(hys_pos),
        .hys_neg(hys_neg), .comparator_b_enable(comparator_b_enable));

    always #5 clk = ~clk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Only the enables and the mode field survive a write
    function automatic logic [7:0] exp_mode(input logic [7:0] w);
        return w & CBMIC_MODE_MASK;
    endfunction

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One idle cycle between strobes keeps each write a single pulse
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk);
        sfr_rd = 1'b0;
        d = sfr_rdata;
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic tally_and_finish;
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Guard against a hang
    initial begin
        #50000;
        fail_count++;
        tally_and_finish;
    end

    initial begin
        logic [7:0] d;
        logic [7:0] v;
        logic [31:0] x;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        rd(CBMIC_MODE_ADDR, d);
        chk("mode reset", d, 8'h02);
        chk("mode out reset", {6'h00, response_mode}, 8'h02);
        rd(CBMIC_CTRL_ADDR, d);
        chk("ctrl reset", d, 8'h00);
        for (int i = 0; i < 8; i++) begin
            x = (i == 0) ? 32'hFF : rnd();
            v = {x[7:2], i[1:0]};
            wr(CBMIC_MODE_ADDR, v);
            rd(CBMIC_MODE_ADDR, d);
            chk("mode readback", d, exp_mode(v));
            chk("response mode", {6'h00, response_mode}, {6'h00, v[1:0]});
            chk("irq flags clear", {7'h00, comparator_b_irq}, 8'h00);
        end
        wr(8'h8A, 8'hFF);
        rd(8'h8A, d);
        chk("unmapped read", d, 8'h00);
        wr(CBMIC_MODE_ADDR, 8'h00);
        wr(CBMIC_CTRL_ADDR, 8'h80);
        tick(3);
        wr(CBMIC_CTRL_ADDR, 8'h80);
        tick(2);
        cmp_result = 1'b1;
        tick(4);
        rd(CBMIC_CTRL_ADDR, d);
        chk("ctrl after rise", d, 8'hE0);
        chk("pin high", {7'h00, comparator_b_pin}, 8'h01);
        chk("irq rise masked", {7'h00, comparator_b_irq}, 8'h00);
        wr(CBMIC_MODE_ADDR, 8'h20);
        tick(2);
        chk("irq rise enabled", {7'h00, comparator_b_irq}, 8'h01);
        wr(CBMIC_MODE_ADDR, 8'h10);
        tick(2);
        chk("irq fall only", {7'h00, comparator_b_irq}, 8'h00);
        cmp_result = 1'b0;
        tick(4);
        rd(CBMIC_CTRL_ADDR, d);
        chk("ctrl after fall", d, 8'hB0);
        chk("irq fall", {7'h00, comparator_b_irq}, 8'h01);
        // Flags stay set while the comparator is switched off
        wr(CBMIC_CTRL_ADDR, 8'h3B);
        for (int i = 0; i < 12; i++) begin
            x = rnd();
            cmp_result = x[0];
            tick(1);
            chk("pin off", {7'h00, comparator_b_pin}, 8'h00);
            chk("irq off", {7'h00, comparator_b_irq}, 8'h00);
        end
        rd(CBMIC_CTRL_ADDR, d);
        chk("ctrl off", d, 8'h3B);
        chk("hysteresis", {4'h0, hys_pos, hys_neg}, 8'h0B);
        chk("enable off", {7'h00, comparator_b_enable}, 8'h00);
        // Re-enable with a quiet input, then clear stale flags as software must
        cmp_result = 1'b0;
        wr(CBMIC_CTRL_ADDR, 8'h80);
        tick(2);
        wr(CBMIC_CTRL_ADDR, 8'h80);
        rd(CBMIC_CTRL_ADDR, d);
        chk("flags cleared", d, 8'h80);
        chk("enable on", {7'h00, comparator_b_enable}, 8'h01);
        // A clearing write in the cycle of an edge loses to the edge
        @(negedge clk);
        sfr_addr = CBMIC_CTRL_ADDR;
        sfr_wdata = 8'h80;
        sfr_wr = 1'b1;
        cmp_result = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
        rd(CBMIC_CTRL_ADDR, d);
        chk("set beats clear", d, 8'hE0);
        // Reset in mid-run returns both registers to their reset values
        rst_n = 1'b0;
        tick(3);
        rst_n = 1'b1;
        rd(CBMIC_MODE_ADDR, d);
        chk("mode after reset", d, CBMIC_MODE_RESET);
        chk("mode out after reset", {6'h00, response_mode}, CBMIC_MODE_RESET);
        rd(CBMIC_CTRL_ADDR, d);
        chk("ctrl after reset", d, 8'h00);
        chk("pin after reset", {7'h00, comparator_b_pin}, 8'h00);
        tally_and_finish;
    end
endmodule
